// File: hdl/ccm_pkg.sv
// constants, types and crc helper for the card control link monitor
package ccm_pkg;
   // ****************************************
   // clocking and timing
   // ****************************************
   localparam int          CLK_NS      = 50;
   localparam int          LOST_NS     = 10000;
   localparam int          LOST_CYC    = (LOST_NS + CLK_NS - 1) / CLK_NS;
   localparam int          TMO_W       = 16;
   localparam longint      BLINK_NS    = 64'd250000000;
   localparam int          BLINK_CYC   = int'(BLINK_NS / CLK_NS);
   localparam int          BLINK_W     = 24;
   // ****************************************
   // card geometry
   // ****************************************
   localparam int          CHANS       = 16;
   localparam int          CARDS       = 8;
   localparam int          AW          = 8;
   localparam logic [7:0]  STROBE_BASE = 8'h21;
   localparam logic [7:0]  STROBE_OFS  = STROBE_BASE - 8'h01;
   // ****************************************
   // message format and result bits
   // ****************************************
   localparam int          WW          = 16;
   localparam int          CNT_LSB     = 0;
   localparam int          CNT_MSB     = 7;
   localparam int          CHK_LSB     = 8;
   localparam int          CHK_MSB     = 15;
   localparam logic [15:0] CRC_INIT    = 16'hffff;
   localparam logic [15:0] CRC_POLY    = 16'h1021;
   localparam int          RES_W       = 4;
   localparam int          RES_OK      = 3;
   localparam int          RES_CRC     = 2;
   localparam int          RES_CNT     = 1;
   localparam int          RES_HDR     = 0;

   typedef enum logic [1:0] {L_IDLE, L_BODY, L_TAIL} ccm_lst_e;

   function automatic logic [15:0] ccm_crc16(input logic [15:0] c, input logic [15:0] d);
      logic [15:0] r;
      logic        fb;
      r = c;
      for (int i = 15; i >= 0; i--) begin
         fb = r[15] ^ d[i];
         r  = {r[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
      end
      return r;
   endfunction
endpackage

// File: hdl/ccm_rx_link.sv
// link clock side: message framing, word count, content and crc checks
`timescale 1ns/1ns
module ccm_rx_link (
   input  wire logic                      link_clk_i,
   input  wire logic                      srst_i,
   input  wire logic                      frame_i,
   input  wire logic [ccm_pkg::WW-1:0]    data_i,
   output logic                           done_tgl_o,
   output logic                           beat_o,
   output logic      [ccm_pkg::RES_W-1:0] res_o
);
   import ccm_pkg::*;

   logic             rs1_r, lrst_r;
   ccm_lst_e         st_r, st_nxt;
   logic [8:0]       left_r, left_nxt;
   logic [15:0]      crc_r, crc_nxt;
   logic             hdr_r, hdr_nxt;
   logic [RES_W-1:0] res_r, res_nxt;
   logic             tgl_r, tgl_nxt;
   logic             beat_r, beat_nxt;
   logic             crc_ok;

   // ****************************************
   // reset into the link domain
   // ****************************************
   always_ff @(posedge link_clk_i) begin
      rs1_r  <= srst_i;
      lrst_r <= rs1_r;
   end

   // ****************************************
   // message checker
   // ****************************************
   always_comb begin
      st_nxt   = st_r;
      left_nxt = left_r;
      crc_nxt  = crc_r;
      hdr_nxt  = hdr_r;
      res_nxt  = res_r;
      tgl_nxt  = tgl_r;
      beat_nxt = ~beat_r;
      crc_ok   = (data_i == crc_r);
      case (st_r)
         L_IDLE: begin
            if (frame_i) begin
               st_nxt   = L_BODY;
               left_nxt = {1'b0, data_i[CNT_MSB:CNT_LSB]} + 9'h001;
               crc_nxt  = ccm_crc16(CRC_INIT, data_i);
               hdr_nxt  = data_i[CHK_MSB:CHK_LSB] != ~data_i[CNT_MSB:CNT_LSB];
            end
         end
         L_BODY: begin
            if (!frame_i) begin
               res_nxt = {1'b0, 1'b0, 1'b1, hdr_r};
               tgl_nxt = ~tgl_r;
               st_nxt  = L_IDLE;
            end else if (left_r == 9'h001) begin
               res_nxt = {crc_ok, ~crc_ok, 1'b0, hdr_r};
               tgl_nxt = ~tgl_r;
               st_nxt  = L_TAIL;
            end else begin
               left_nxt = left_r - 9'h001;
               crc_nxt  = ccm_crc16(crc_r, data_i);
            end
         end
         L_TAIL: begin
            if (!frame_i) begin
               st_nxt = L_IDLE;
            end else begin
               res_nxt = {1'b0, 1'b0, 1'b1, 1'b0};
               tgl_nxt = ~tgl_r;
            end
         end
         default: st_nxt = L_IDLE;
      endcase
   end

   always_ff @(posedge link_clk_i) begin
      if (lrst_r) begin
         st_r   <= L_IDLE;
         left_r <= 9'h000;
         crc_r  <= CRC_INIT;
         hdr_r  <= 1'b0;
         res_r  <= '0;
         tgl_r  <= 1'b0;
         beat_r <= 1'b0;
      end else begin
         st_r   <= st_nxt;
         left_r <= left_nxt;
         crc_r  <= crc_nxt;
         hdr_r  <= hdr_nxt;
         res_r  <= res_nxt;
         tgl_r  <= tgl_nxt;
         beat_r <= beat_nxt;
      end
   end

   assign done_tgl_o = tgl_r;
   assign beat_o     = beat_r;
   assign res_o      = res_r;

   // ****************************************
   // checks
   // ****************************************
   a_crc_bad_report: assert property (@(posedge link_clk_i) disable iff (lrst_r)
      (st_r == L_BODY && frame_i && left_r == 9'h001 && data_i != crc_r)
      |=> (res_r[RES_CRC] && !res_r[RES_OK] && tgl_r != $past(tgl_r)))
      else $error("bad crc not reported");
   a_short_msg: assert property (@(posedge link_clk_i) disable iff (lrst_r)
      (st_r == L_BODY && !frame_i) |=> (res_r[RES_CNT] && st_r == L_IDLE))
      else $error("short message not flagged");
endmodule

// File: hdl/ccm_monitor.sv
// card control link error monitor with strobe and video path
`timescale 1ns/1ns
// Functional notes
// - input card: bad crc lights indicator steadily
// - input card: lost link blinks indicator
// - input card: only good crc clears error
// - output card: crc mismatch is steady error
// - output card: word count, corrupt content flag error
// - output card: error holds until good crc
// - output card: missing receive clock blinks indicator
// - monitor strobe base 33, frame strobe plus 32
// - merge eight cards, then retime or bypass
// - input card: 16 channels distributed unchanged
module ccm_monitor #(
   parameter int BLINK_CYC_P = ccm_pkg::BLINK_CYC,
   parameter int LOST_CYC_P  = ccm_pkg::LOST_CYC
) (
   input  wire logic                                   clk_i,
   input  wire logic                                   srst_i,
   input  wire logic                                   link_clk_i,
   input  wire logic                                   link_frame_i,
   input  wire logic [ccm_pkg::WW-1:0]                 link_data_i,
   input  wire logic                                   card_out_i,
   input  wire logic                                   rate_sel_i,
   input  wire logic [ccm_pkg::AW-1:0]                 frame_strobe_i,
   input  wire logic [ccm_pkg::AW-1:0]                 addr_i,
   input  wire logic [ccm_pkg::CHANS-1:0]              vid_in_i,
   input  wire logic [ccm_pkg::CARDS*ccm_pkg::CHANS-1:0] mat_i,
   output logic                                        led_o,
   output logic                                        ctl_err_o,
   output logic                                        clk_lost_o,
   output logic      [ccm_pkg::AW-1:0]                 strobe_o,
   output logic                                        mon_sel_o,
   output logic      [ccm_pkg::CHANS-1:0]              vid_dist_o,
   output logic      [ccm_pkg::CHANS-1:0]              vid_out_o
);
   import ccm_pkg::*;

   localparam int PW = 2 + 2 * AW + CHANS + CARDS * CHANS;

   logic                 l_tgl, l_beat;
   logic [RES_W-1:0]     l_res;
   logic [PW-1:0]        p1_r, p2_r;
   logic                 t1_r, t2_r, td_r, b1_r, b2_r, bd_r;
   logic                 card_out_s, rate_s;
   logic [AW-1:0]        fs_s, addr_s;
   logic [CHANS-1:0]     vin_s;
   logic [CARDS*CHANS-1:0] mat_s;
   logic [CHANS-1:0]     merged;
   logic                 evt, bevt, set_err, clr_err;
   logic [TMO_W-1:0]     tmo_r, tmo_nxt;
   logic                 lost_r, lost_nxt;
   logic                 err_r, err_nxt;
   logic [BLINK_W-1:0]   bc_r, bc_nxt;
   logic                 blink_r, blink_nxt;
   logic                 led_r, led_nxt;
   logic [AW-1:0]        strobe_r, strobe_nxt;
   logic                 sel_r, sel_nxt;
   logic [CHANS-1:0]     dist_r, dist_nxt, ret_r, ret_nxt, out_r, out_nxt;

   // ****************************************
   // link receiver
   // ****************************************
   ccm_rx_link u_link (
      .link_clk_i (link_clk_i),
      .srst_i     (srst_i),
      .frame_i    (link_frame_i),
      .data_i     (link_data_i),
      .done_tgl_o (l_tgl),
      .beat_o     (l_beat),
      .res_o      (l_res)
   );

   // ****************************************
   // synchronisers
   // ****************************************
   always_ff @(posedge clk_i) begin
      p1_r <= {card_out_i, rate_sel_i, frame_strobe_i, addr_i, vid_in_i, mat_i};
      p2_r <= p1_r;
      t1_r <= l_tgl;
      t2_r <= t1_r;
      b1_r <= l_beat;
      b2_r <= b1_r;
   end

   assign {card_out_s, rate_s, fs_s, addr_s, vin_s, mat_s} = p2_r;

   // ****************************************
   // output combiner merge
   // ****************************************
   generate
      for (genvar ch = 0; ch < CHANS; ch++) begin : g_ch
         logic [CARDS-1:0] col;
         for (genvar cd = 0; cd < CARDS; cd++) begin : g_cd
            assign col[cd] = mat_s[cd*CHANS+ch];
         end
         assign merged[ch] = |col;
      end
   endgenerate

   // ****************************************
   // error and clock supervision
   // ****************************************
   always_comb begin
      evt     = t2_r ^ td_r;
      bevt    = b2_r ^ bd_r;
      set_err = evt && (l_res[RES_CRC] ||
                card_out_s && (l_res[RES_CNT] || l_res[RES_HDR]));
      clr_err = evt && l_res[RES_OK];
      err_nxt = set_err || (err_r && !clr_err);
      if (bevt) begin
         tmo_nxt  = '0;
         lost_nxt = 1'b0;
      end else begin
         tmo_nxt  = (tmo_r == TMO_W'(LOST_CYC_P)) ? tmo_r : tmo_r + 1'b1;
         lost_nxt = lost_r || (tmo_r == TMO_W'(LOST_CYC_P - 1));
      end
      if (bc_r == BLINK_W'(BLINK_CYC_P - 1)) begin
         bc_nxt    = '0;
         blink_nxt = ~blink_r;
      end else begin
         bc_nxt    = bc_r + 1'b1;
         blink_nxt = blink_r;
      end
      led_nxt    = lost_r ? blink_r : err_r;
      strobe_nxt = fs_s + STROBE_OFS;
      sel_nxt    = (addr_s == strobe_r);
      dist_nxt   = vin_s;
      ret_nxt    = merged;
      out_nxt    = rate_s ? ret_r : merged;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         td_r     <= 1'b0;
         bd_r     <= 1'b0;
         tmo_r    <= '0;
         lost_r   <= 1'b0;
         err_r    <= 1'b0;
         bc_r     <= '0;
         blink_r  <= 1'b0;
         led_r    <= 1'b0;
         strobe_r <= '0;
         sel_r    <= 1'b0;
         dist_r   <= '0;
         ret_r    <= '0;
         out_r    <= '0;
      end else begin
         td_r     <= t2_r;
         bd_r     <= b2_r;
         tmo_r    <= tmo_nxt;
         lost_r   <= lost_nxt;
         err_r    <= err_nxt;
         bc_r     <= bc_nxt;
         blink_r  <= blink_nxt;
         led_r    <= led_nxt;
         strobe_r <= strobe_nxt;
         sel_r    <= sel_nxt;
         dist_r   <= dist_nxt;
         ret_r    <= ret_nxt;
         out_r    <= out_nxt;
      end
   end

   assign led_o      = led_r;
   assign ctl_err_o  = err_r;
   assign clk_lost_o = lost_r;
   assign strobe_o   = strobe_r;
   assign mon_sel_o  = sel_r;
   assign vid_dist_o = dist_r;
   assign vid_out_o  = out_r;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);

   a_crc_sets_err: assert property (evt && l_res[RES_CRC] |=> err_r ##1 (lost_r || led_o))
      else $error("bad crc did not light indicator");
   a_err_holds: assert property (err_r && !(evt && l_res[RES_OK]) |=> err_r)
      else $error("error cleared without good crc");
   a_out_cnt_err: assert property (evt && card_out_s && l_res[RES_CNT] |=> err_r)
      else $error("word count error not flagged");
   a_steady_led: assert property (!lost_r && err_r |=> led_o)
      else $error("steady indicator missing");
   a_lost_blink: assert property (lost_r |=> led_o == $past(blink_r))
      else $error("indicator not blinking on lost clock");
   a_lost_time: assert property (!bevt && tmo_r == TMO_W'(LOST_CYC_P - 1) |=> lost_r)
      else $error("lost clock not declared");
   a_clk_resume: assert property (bevt |=> !lost_r && tmo_r == '0)
      else $error("lost clock not cleared on edge");
   a_strobe_ofs: assert property (1'b1 |=> strobe_o == $past(fs_s) + 8'h20)
      else $error("monitor strobe offset wrong");
   a_bypass_path: assert property (!rate_s |=> vid_out_o == $past(merged))
      else $error("bypass path wrong");
   a_in_dist: assert property (1'b1 |=> vid_dist_o == $past(vin_s))
      else $error("input distribution wrong");
   a_good_clears: assert property (
      evt && l_res == RES_W'(1 << RES_OK) |=> !err_r)
      else $error("good crc did not clear error");
   a_in_only_crc: assert property (
      evt && !card_out_s && !l_res[RES_CRC] && !err_r |=> !err_r)
      else $error("input card flagged non crc error");
   a_dark_led: assert property (
      !lost_r && !err_r |=> !led_o)
      else $error("indicator lit without error");
   a_retime_path: assert property (
      rate_s ##1 rate_s |=> vid_out_o == $past(merged, 2))
      else $error("retimed path wrong");
   a_sel_match: assert property (
      addr_s == strobe_o |=> mon_sel_o)
      else $error("monitor select missing");

   // ****************************************
   // scenario covers
   // ****************************************
   c_err_cleared: cover property (err_r ##1 !err_r);
   c_clk_lost: cover property (!lost_r ##1 lost_r);
   c_good_msg: cover property (evt && l_res[RES_OK]);
   c_content_err: cover property (evt && card_out_s && l_res[RES_HDR]);
   c_led_blink: cover property (lost_r && led_o ##1 lost_r && !led_o);
endmodule

// File: dv/ccm_ctrl_model.sv
// frame controller model: link clock and framed control messages
`timescale 1ns/1ns
module ccm_ctrl_model (
   output logic        link_clk_o,
   output logic        frame_o,
   output logic [15:0] data_o
);
   logic        run;
   logic [15:0] crc;
   initial begin
      run = 1'b1;
      link_clk_o = 1'b0;
      frame_o = 1'b0;
      data_o = 16'h0000;
      forever begin
         #24;
         if (run) link_clk_o = ~link_clk_o;
      end
   end
   function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [15:0] d);
      for (int i = 15; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h1021 : 16'h0000);
      return c;
   endfunction
   task automatic put(input logic [15:0] w);
      @(negedge link_clk_o);
      frame_o = 1'b1;
      data_o = w;
      crc = crc_upd(crc, w);
   endtask
   // mode 0 good, 1 bad crc, 2 frame ends before crc word, 3 bad check field
   task automatic send(input logic [7:0] cnt, input int mode);
      logic [15:0] c;
      crc = 16'hffff;
      put(mode == 3 ? {cnt, cnt} : {~cnt, cnt});
      for (int i = 0; i < int'(cnt); i++) put(16'h5a00 + 16'(i));
      c = crc ^ ((mode == 1) ? 16'h0001 : 16'h0000);
      if (mode != 2) put(c);
      @(negedge link_clk_o);
      frame_o = 1'b0;
      data_o = ~data_o;
   endtask
endmodule

// File: dv/test_card_control_link_error_monitor.sv
// self-checking bench for the card control link error monitor
`timescale 1ns/1ns
module test_card_control_link_error_monitor;
   import ccm_pkg::*;
   logic                   clk_i, srst_i, lclk, frame, card_out_i, rate_sel_i;
   logic [15:0]            data;
   logic [AW-1:0]          frame_strobe_i, addr_i, strobe_o;
   logic [CHANS-1:0]       vid_in_i, vid_dist_o, vid_out_o;
   logic [CARDS*CHANS-1:0] mat_i;
   logic                   led_o, ctl_err_o, clk_lost_o, mon_sel_o;
   int                     miscompares, comparisons;
   ccm_ctrl_model i_ctrl (.link_clk_o(lclk), .frame_o(frame), .data_o(data));
   ccm_monitor #(.BLINK_CYC_P(8), .LOST_CYC_P(20)) i_dut (
      .clk_i(clk_i), .srst_i(srst_i), .link_clk_i(lclk), .link_frame_i(frame),
      .link_data_i(data), .card_out_i(card_out_i), .rate_sel_i(rate_sel_i),
      .frame_strobe_i(frame_strobe_i), .addr_i(addr_i), .vid_in_i(vid_in_i),
      .mat_i(mat_i), .led_o(led_o), .ctl_err_o(ctl_err_o), .clk_lost_o(clk_lost_o),
      .strobe_o(strobe_o), .mon_sel_o(mon_sel_o), .vid_dist_o(vid_dist_o),
      .vid_out_o(vid_out_o));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic conclude();
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // error flag reaches exp within a bound, indicator follows next cycle
   task automatic wait_err(input logic exp, input bit hold);
      int n;
      n = 0;
      if (hold) tick(40);
      while (ctl_err_o !== exp && n < 60) begin
         tick(1);
         n++;
      end
      cmp(ctl_err_o, exp);
      if (ctl_err_o !== exp) conclude();
      tick(1);
      cmp(led_o, exp);
   endtask
   task automatic wait_lost(input logic exp);
      int n;
      n = 0;
      while (clk_lost_o !== exp && n < 60) begin
         tick(1);
         n++;
      end
      cmp(clk_lost_o, exp);
      if (clk_lost_o !== exp) conclude();
   endtask
   task automatic test_input_card();
      card_out_i = 1'b0;
      i_ctrl.send(8'h02, 0); wait_err(1'b0, 1);
      i_ctrl.send(8'h03, 1); wait_err(1'b1, 0);
      i_ctrl.send(8'h02, 2); wait_err(1'b1, 1);
      i_ctrl.send(8'h00, 0); wait_err(1'b0, 0);
      i_ctrl.send(8'h01, 3); wait_err(1'b0, 1);
      $display("test_input_card done");
   endtask
   task automatic test_output_card();
      card_out_i = 1'b1;
      i_ctrl.send(8'h02, 2); wait_err(1'b1, 0);
      i_ctrl.send(8'h01, 0); wait_err(1'b0, 0);
      i_ctrl.send(8'h04, 3); wait_err(1'b1, 0);
      i_ctrl.send(8'h00, 1); wait_err(1'b1, 1);
      i_ctrl.send(8'h00, 0); wait_err(1'b0, 0);
      i_ctrl.send(8'hff, 1); wait_err(1'b1, 0);
      i_ctrl.send(8'h01, 0); wait_err(1'b0, 0);
      $display("test_output_card done");
   endtask
   task automatic test_clock_loss();
      int   flips;
      logic last;
      for (int k = 1; k >= 0; k--) begin
         card_out_i = 1'(k);
         flips = 0;
         i_ctrl.run = 1'b0;
         tick(10);
         cmp(clk_lost_o, 1'b0);
         wait_lost(1'b1);
         last = led_o;
         repeat (40) begin
            tick(1);
            if (led_o !== last) flips++;
            last = led_o;
         end
         cmp(16'(flips >= 4), 16'h0001);
         cmp(ctl_err_o, 1'b0);
         i_ctrl.run = 1'b1;
         wait_lost(1'b0);
         tick(3);
         cmp(led_o, 1'b0);
      end
      $display("test_clock_loss done");
   endtask
   task automatic test_strobe();
      frame_strobe_i = 8'h01;
      addr_i = 8'h21;
      tick(6);
      cmp(strobe_o, 8'h21);
      cmp(mon_sel_o, 1'b1);
      frame_strobe_i = 8'h0a;
      tick(6);
      cmp(strobe_o, 8'h2a);
      cmp(mon_sel_o, 1'b0);
      addr_i = 8'h2a;
      tick(6);
      cmp(mon_sel_o, 1'b1);
      $display("test_strobe done");
   endtask
   task automatic test_video();
      vid_in_i = 16'ha5c3;
      mat_i = '0;
      mat_i[7*16+3] = 1'b1;
      mat_i[15] = 1'b1;
      mat_i[2*16+3] = 1'b1;
      for (int r = 0; r < 2; r++) begin
         rate_sel_i = 1'(r);
         tick(6);
         cmp(vid_out_o, 16'h8008);
         cmp(vid_dist_o, 16'ha5c3);
      end
      mat_i = '0;
      tick(3);
      cmp(vid_out_o, 16'h8008);
      tick(3);
      cmp(vid_out_o, 16'h0000);
      rate_sel_i = 1'b0;
      tick(6);
      mat_i[15] = 1'b1;
      tick(3);
      cmp(vid_out_o, 16'h8000);
      $display("test_video done");
   endtask
   initial begin
      srst_i = 1'b1;
      card_out_i = 1'b0;
      rate_sel_i = 1'b0;
      frame_strobe_i = 8'h00;
      addr_i = 8'h00;
      vid_in_i = 16'h0000;
      mat_i = '0;
      miscompares = 0;
      comparisons = 0;
      tick(6);
      cmp(led_o, 1'b0);
      cmp(ctl_err_o, 1'b0);
      srst_i = 1'b0;
      tick(4);
      test_input_card();
      test_output_card();
      test_clock_loss();
      test_strobe();
      test_video();
      conclude();
   end
endmodule
